// ---- dlcpc_ctrl.sv ----
// Register, load, clear and power-down control of a one-channel 16-bit DAC
`timescale 1ns/1ps

// Overview of operation
// - Load pin low copies preload into output register immediately.
// - Load pin is a level; held low, output follows at frame end.
// - Software load command copies preload into output register.
// - Plain write goes to preload, or both registers in write-through mode.
// - Write-and-update loads preload and output regardless of mode.
// - Write-all loads preload and output with one word regardless of mode.
// - Clear pin low forces output to zero or midscale per level pin.
// - Software clear command acts like the clear pin.
// - Reset loads defaults; output level follows the power-up level pin.
// - Power-down command selects floating or pulled-down output.
// - Power-down disables amplifier and ladder; registers stay usable.
// - Data registers read and write; mode report is read only.
// - Data registers hold 16-bit straight binary, bit 15 most significant.
// - Mode report bits 7 to 3 reserved; read as zero here.
// - Mode report bit 2 shows the block-mode bit.
// - Bit 1 shows pulled-down power-down, bit 0 floating power-down.
// - Frame is command byte then 16 data bits, MSB first.
// - Channel address in command low bits; load and block commands use data mask.
// - Power-down upper byte floats, lower pulls down; pull-down wins.
// - Register read takes two frames: load, then shift out.
module dlcpc_ctrl
    import dlcpc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    // Serial interface pins
    input  wire logic        select_bar_n_i,
    input  wire logic        sclk_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_n_o,
    // Side-band pins
    input  wire logic        load_output_pin_n_i,
    input  wire logic        clear_pin_n_i,
    input  wire logic        powerup_level_pin_i,
    // Converter core controls
    output logic [15:0]      output_code_o,
    output logic             amp_enable_o,
    output logic             ladder_connect_o,
    output logic             pulldown_en_o,
    output logic             output_float_o
);

    // Code that matches the selected power-up level
    function automatic logic [15:0] level_code(input logic mid);
        level_code = mid ? CODE_MID : CODE_ZERO;
    endfunction

    // Addressed command whose channel field names channel 0
    function automatic logic op_hit(input logic [7:0] cmd,
                                    input logic [4:0] op);
        op_hit = (cmd[7:3] == op) && (cmd[2:0] == CHAN_ZERO);
    endfunction

    logic [SY_N-1:0]   sync1_q;
    logic [SY_N-1:0]   sync2_q;
    logic              csb_prev_q;
    logic              sck_prev_q;
    logic [23:0]       shreg_q;
    logic [CNT_W-1:0]  bitcnt_q;
    logic              sdo_q;
    logic              oe_n_q;
    logic [15:0]       preload_q;
    logic [15:0]       output_q;
    logic              block_q;
    logic              pd_float_q;
    logic              pd_pulldn_q;
    dlcpc_state_type   state_q;
    dlcpc_state_type   state_d;
    logic [1:0]        boot_q;
    logic              amp_on_q;

    logic              csb_s;
    logic              sck_rise;
    logic              sck_fall;
    logic              cs_fall;
    logic              cs_rise;
    logic              frame_done;
    logic [7:0]        cmd;
    logic [15:0]       data;
    logic              do_clear;
    logic              clear_any;
    logic              do_load;
    logic              load_any;
    logic              do_write;
    logic              do_wr_upd;
    logic              do_wr_all;
    logic              do_block;
    logic              do_pdown;
    logic [CFG_W-1:0]  cfg_report;

    // Two flops on every pin; only stage two is read
    // Reset value is the idle level of select and of the active-low pins
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= {powerup_level_pin_i, clear_pin_n_i, load_output_pin_n_i,
                         sdi_i, sclk_i, select_bar_n_i};
            sync2_q <= sync1_q;
        end
    end

    // Previous samples for edge detection
    // A stray clock edge just after reset is masked while select reads high
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            csb_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            csb_prev_q <= sync2_q[SY_CSB];
            sck_prev_q <= sync2_q[SY_SCK];
        end
    end

    // Serial edges; clock edges count only inside a frame
    assign csb_s    = sync2_q[SY_CSB];
    assign cs_fall  = csb_prev_q & ~csb_s;
    assign cs_rise  = ~csb_prev_q & csb_s;
    assign sck_rise = ~csb_s & ~sck_prev_q & sync2_q[SY_SCK];
    assign sck_fall = ~csb_s & sck_prev_q & ~sync2_q[SY_SCK];

    // frame decode
    // Short frames are dropped; long ones keep the last 24 bits
    assign frame_done = cs_rise && (bitcnt_q == FRAME_FULL);
    assign cmd        = shreg_q[23:16];
    assign data       = shreg_q[15:0];

    // command decode
    // Load and block-mode commands look at the channel-0 mask bit
    always_comb begin
        do_clear  = frame_done && (cmd == CMD_CLEAR);
        do_load   = frame_done && (cmd == CMD_LOAD) && data[MASK_CH0];
        do_block  = frame_done && (cmd == CMD_BLOCK);
        do_pdown  = frame_done && (cmd == CMD_PDOWN);
        do_wr_all = frame_done && (cmd == CMD_WR_ALL);
        do_write  = frame_done && op_hit(cmd, OP_WRITE);
        do_wr_upd = frame_done && op_hit(cmd, OP_WR_UPD);
    end

    assign clear_any = ~sync2_q[SY_CLR] | do_clear;
    assign load_any  = ~sync2_q[SY_LOAD] | do_load;

    // Built fresh each cycle, so a read always sees the current modes
    // reserved as zero
    always_comb begin
        cfg_report             = '0;
        cfg_report[CFG_BLOCK]  = block_q;
        cfg_report[CFG_PULLDN] = pd_pulldn_q;
        cfg_report[CFG_FLOAT]  = pd_float_q;
    end

    // Frame bit counter, saturates at a full frame
    // Stopping at 24 lets daisy-chained frames of 24 bits or more still decode
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bitcnt_q <= '0;
        end else if (cs_fall) begin
            bitcnt_q <= '0;
        end else if (sck_rise && bitcnt_q != FRAME_FULL) begin
            bitcnt_q <= bitcnt_q + 5'h01;
        end
    end

    // registers read back
    // Command byte is kept so the second frame echoes it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shreg_q <= '0;
        end else if (sck_rise) begin
            shreg_q <= {shreg_q[22:0], sync2_q[SY_SDI]};
        end else if (frame_done && op_hit(cmd, OP_RD_PRE)) begin
            shreg_q[15:0] <= preload_q;
        end else if (frame_done && op_hit(cmd, OP_RD_OUT)) begin
            shreg_q[15:0] <= output_q;
        end else if (frame_done && op_hit(cmd, OP_RD_CFG)) begin
            shreg_q[15:0] <= {8'h00, cfg_report};
        end
    end

    // Serial output: MSB at select fall, next bit on each clock fall
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdo_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= csb_s;
            if (cs_fall || sck_fall) begin
                sdo_q <= shreg_q[23];
            end
        end
    end

    // start-up sequence
    // Async reset takes constants, so the synchronisers read high at first.
    // Stay in start-up until the level pin has crossed both flops; leaving
    // after one edge would latch the synchroniser's reset value and power
    // up at midscale whatever the pin says.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT: begin
                if (boot_q[1]) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN:  state_d = ST_RUN;
            default: state_d = ST_INIT;
        endcase
    end

    // Start-up delay: two flops of ones, matching the synchroniser depth
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_q <= 2'h0;
        end else begin
            boot_q <= {boot_q[0], 1'b1};
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Preload register
    // Writes are refused during start-up and while clear holds
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            preload_q <= CODE_ZERO;
        end else if (state_q == ST_INIT) begin
            preload_q <= level_code(sync2_q[SY_LVL]);
        end else if (clear_any) begin
            preload_q <= level_code(sync2_q[SY_LVL]);
        end else if (do_write || do_wr_upd || do_wr_all) begin
            preload_q <= data;
        end
    end

    // Output register; clear beats writes, writes beat the load transfer
    // A clear pin held low therefore also overrides the load pin
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            output_q <= CODE_ZERO;
        end else if (state_q == ST_INIT) begin
            output_q <= level_code(sync2_q[SY_LVL]);
        end else if (clear_any) begin
            output_q <= level_code(sync2_q[SY_LVL]);
        end else if (do_wr_upd || do_wr_all || (do_write && !block_q)) begin
            output_q <= data;
        end else if (do_write && !sync2_q[SY_LOAD]) begin
            // load pin held
            // A blocked write under a low load pin lands in both registers
            // at the frame close, so the output does not lag by a cycle
            output_q <= data;
        end else if (load_any) begin
            // transfer
            // Pin held low keeps copying the preload every cycle
            output_q <= preload_q;
        end
    end

    // Block-mode bit, written by configuration command; clear and reset load BLOCK_RST
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            block_q <= BLOCK_RST;
        end else if (clear_any) begin
            block_q <= BLOCK_RST;
        end else if (do_block) begin
            block_q <= data[MASK_CH0];
        end
    end

    // Power-down selection
    // A power-down command with both bytes clear wakes the channel
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pd_float_q  <= PD_RST;
            pd_pulldn_q <= PD_RST;
        end else if (clear_any) begin
            pd_float_q  <= PD_RST;
            pd_pulldn_q <= PD_RST;
        end else if (do_pdown) begin
            pd_pulldn_q <= data[PD_PULLDN];
            pd_float_q  <= data[PD_FLOAT] & ~data[PD_PULLDN];
        end
    end

    // analog path enable
    // A flop of its own so the core controls leave the block registered;
    // it follows the same command as the two select bits
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            amp_on_q <= ~PD_RST;
        end else if (clear_any) begin
            amp_on_q <= ~PD_RST;
        end else if (do_pdown) begin
            amp_on_q <= ~(data[PD_FLOAT] | data[PD_PULLDN]);
        end
    end

    // core controls
    // Only the analog path sleeps; serial logic and registers keep running
    assign amp_enable_o     = amp_on_q;
    assign ladder_connect_o = amp_on_q;
    assign pulldown_en_o    = pd_pulldn_q;
    assign output_float_o   = pd_float_q;

    assign output_code_o = output_q;
    assign sdo_o         = sdo_q;
    assign sdo_oe_n_o    = oe_n_q;

endmodule

// ---- dlcpc_ctrl_props.sv ----
// Port assertions for the DAC control block
`timescale 1ns/1ps
module dlcpc_ctrl_props
    import dlcpc_pkg::*;
(
    // Clock, reset and pins
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        select_bar_n_i,
    input wire logic        load_output_pin_n_i,
    input wire logic        clear_pin_n_i,
    input wire logic        powerup_level_pin_i,
    // Outputs
    input wire logic        sdo_oe_n_o,
    input wire logic [15:0] output_code_o,
    input wire logic        amp_enable_o,
    input wire logic        ladder_connect_o,
    input wire logic        pulldown_en_o,
    input wire logic        output_float_o
);
    // Single domain; pins are synced, so windows allow for that lag
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_reset_code: assert property ($rose(nrst_i) |-> ##5
        output_code_o == (powerup_level_pin_i ? CODE_MID : CODE_ZERO)) else $error("reset code");
    a_clear_code: assert property ((!clear_pin_n_i && $stable(powerup_level_pin_i)) [*7]
        |-> output_code_o == (powerup_level_pin_i ? CODE_MID : CODE_ZERO)) else $error("clear");
    a_clear_awake: assert property (!clear_pin_n_i [*7]
        |-> amp_enable_o && !pulldown_en_o && !output_float_o) else $error("clear pd");
    a_pd_amp_off: assert property ((pulldown_en_o || output_float_o)
        |-> !amp_enable_o && !ladder_connect_o) else $error("pd amp");
    a_active_amp_on: assert property ((!pulldown_en_o && !output_float_o)
        |-> amp_enable_o && ladder_connect_o) else $error("amp on");
    a_pd_one_mode: assert property (!(pulldown_en_o && output_float_o))
        else $error("pd modes");
    a_code_quiet: assert property (
        (select_bar_n_i && clear_pin_n_i && $stable(load_output_pin_n_i)) [*8]
        |-> $stable(output_code_o)) else $error("code moved");
    a_oe_on: assert property (!select_bar_n_i [*5] |-> !sdo_oe_n_o)
        else $error("oe on");
    a_oe_off: assert property (select_bar_n_i [*5] |-> sdo_oe_n_o)
        else $error("oe off");
endmodule

bind dlcpc_ctrl dlcpc_ctrl_props u_dlcpc_ctrl_props (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .select_bar_n_i(select_bar_n_i),
    .load_output_pin_n_i(load_output_pin_n_i), .clear_pin_n_i(clear_pin_n_i),
    .powerup_level_pin_i(powerup_level_pin_i), .sdo_oe_n_o(sdo_oe_n_o),
    .output_code_o(output_code_o), .amp_enable_o(amp_enable_o),
    .ladder_connect_o(ladder_connect_o), .pulldown_en_o(pulldown_en_o),
    .output_float_o(output_float_o));

// ---- dlcpc_master.sv ----
// Behavioural serial master that frames commands for the block
`timescale 1ns/1ps
module dlcpc_master (
    // Clock and pace
    input  wire logic       sys_clk_i,
    input  wire logic [3:0] half_i,
    // Serial pins
    input  wire logic       sdo_i,
    output logic            select_bar_n_o,
    output logic            sclk_o,
    output logic            sdi_o
);
    // Idle: deselected, clock parked low
    initial begin
        select_bar_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge sys_clk_i);
        select_bar_n_o = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        for (int i = 23; i >= 0; i--) begin
            sdi_o = tx[i];
            repeat (half_i) @(negedge sys_clk_i);
            rx = {rx[22:0], sdo_i};
            sclk_o = 1'b1;
            repeat (half_i) @(negedge sys_clk_i);
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge sys_clk_i);
        select_bar_n_o = 1'b1;
        // Flip the idle data so a stale bit never passes as valid
        sdi_o = ~sdi_o;
        repeat (12) @(negedge sys_clk_i);
    endtask
endmodule

// ---- dlcpc_pkg.sv ----
// Constants and types for the DAC load, clear and power-down control block
package dlcpc_pkg;

    // Serial frame layout: command byte then 16-bit data, MSB first
    localparam int          FRAME_BITS  = 24;
    localparam int          CNT_W       = 5;
    localparam logic [4:0]  FRAME_FULL  = 5'h18;
    localparam int          DATA_W      = 16;
    localparam int          CFG_W       = 8;

    // Configuration commands, full command byte
    localparam logic [7:0]  CMD_NOP     = 8'h00;
    localparam logic [7:0]  CMD_CLEAR   = 8'h01;
    localparam logic [7:0]  CMD_LOAD    = 8'h18;
    localparam logic [7:0]  CMD_BLOCK   = 8'h28;
    localparam logic [7:0]  CMD_PDOWN   = 8'h30;
    localparam logic [7:0]  CMD_WR_ALL  = 8'h20;

    // Addressed commands: upper five bits, channel in the low three
    localparam logic [4:0]  OP_WRITE    = 5'h01;
    localparam logic [4:0]  OP_WR_UPD   = 5'h02;
    localparam logic [4:0]  OP_RD_PRE   = 5'h11;
    localparam logic [4:0]  OP_RD_OUT   = 5'h12;
    localparam logic [4:0]  OP_RD_CFG   = 5'h13;
    localparam logic [2:0]  CHAN_ZERO   = 3'h0;

    // Channel-mask and power-down field positions in the data word
    localparam int          MASK_CH0    = 0;
    localparam int          PD_FLOAT    = 8;
    localparam int          PD_PULLDN   = 0;

    // Mode report bit positions
    localparam int          CFG_BLOCK   = 2;
    localparam int          CFG_PULLDN  = 1;
    localparam int          CFG_FLOAT   = 0;

    // Values after reset
    localparam logic [15:0] CODE_ZERO   = 16'h0000;
    localparam logic [15:0] CODE_MID    = 16'h8000;
    localparam logic        BLOCK_RST   = 1'b1;
    localparam logic        PD_RST      = 1'b0;

    // Synchroniser slots
    localparam int          SY_CSB      = 0;
    localparam int          SY_SCK      = 1;
    localparam int          SY_SDI      = 2;
    localparam int          SY_LOAD     = 3;
    localparam int          SY_CLR      = 4;
    localparam int          SY_LVL      = 5;
    localparam int          SY_N        = 6;

    // Start-up sequence
    typedef enum logic {
        ST_INIT,
        ST_RUN
    } dlcpc_state_type;

endpackage

// ---- tb_dlcpc_ctrl.sv ----
// Self-checking bench: frames and pins against expected values
`timescale 1ns/1ps
module tb_dlcpc_ctrl;
    import dlcpc_pkg::*;
    // Pins and bench state
    logic        sys_clk_i;
    logic        nrst_i;
    logic        csb_n, sclk, sdi, sdo, oe_n, ld_n, clr_n, lvl, amp, lad, pdn, flt;
    logic [15:0] code, v;
    logic [3:0]  half = 4'h5;
    int          n_fail = 0, num_checks = 0, cycles = 0;
    logic [15:0] pd_dat [4] = '{16'h0100, 16'h0001, 16'h0101, 16'h0000};
    logic [1:0]  pd_rep [4] = '{2'h1, 2'h2, 2'h2, 2'h0};

    dlcpc_ctrl u_dlcpc_ctrl (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .select_bar_n_i(csb_n),
        .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(oe_n), .load_output_pin_n_i(ld_n),
        .clear_pin_n_i(clr_n), .powerup_level_pin_i(lvl), .output_code_o(code),
        .amp_enable_o(amp), .ladder_connect_o(lad), .pulldown_en_o(pdn), .output_float_o(flt));
    // Released data line reads as the inverse of its last value
    dlcpc_master u_dlcpc_master (.sys_clk_i(sys_clk_i), .half_i(half), .sdo_i(oe_n ? ~sdo : sdo),
        .select_bar_n_o(csb_n), .sclk_o(sclk), .sdi_o(sdi));

    // 40 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard, well above the roughly 11k cycles of traffic
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] dat);
        logic [23:0] rx;
        u_dlcpc_master.xfer({cmd, dat}, rx);
    endtask

    // Two frames: load the chain, then shift out echo and register
    task automatic rd(input logic [4:0] op, output logic [15:0] val);
        logic [23:0] rx;
        u_dlcpc_master.xfer({op, CHAN_ZERO, 16'h0000}, rx);
        u_dlcpc_master.xfer({CMD_NOP, 16'h0000}, rx);
        check("echo", rx[23:16], {op, CHAN_ZERO});
        val = rx[15:0];
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // Main sequence
    initial begin
        nrst_i = 1'b0;
        {ld_n, clr_n, lvl} = 3'h7;
        wait_n(2);
        nrst_i = 1'b1;
        wait_n(8);
        check("code", code, CODE_MID);
        rd(OP_RD_CFG, v);
        check("report", v & 16'h0007, 16'h0004);
        wr({OP_WRITE, CHAN_ZERO}, 16'h1234);
        check("code", code, CODE_MID);
        rd(OP_RD_PRE, v);
        check("preload", v, 16'h1234);
        half = 4'h9;
        wr(CMD_LOAD, 16'h0001);
        half = 4'h5;
        check("code", code, 16'h1234);
        wr(CMD_BLOCK, 16'h0000);
        rd(OP_RD_CFG, v);
        check("report", v & 16'h0007, 16'h0000);
        wr({OP_WRITE, CHAN_ZERO}, 16'habcd);
        check("code", code, 16'habcd);
        wr(CMD_BLOCK, 16'h0001);
        wr({OP_WR_UPD, CHAN_ZERO}, 16'h00ff);
        check("code", code, 16'h00ff);
        wr(CMD_WR_ALL, 16'hfffe);
        rd(OP_RD_OUT, v);
        check("output", v, 16'hfffe);
        wr({OP_WRITE, CHAN_ZERO}, 16'h5555);
        ld_n = 1'b0;
        wait_n(8);
        check("code", code, 16'h5555);
        wr({OP_WRITE, CHAN_ZERO}, 16'h6666);
        check("code", code, 16'h6666);
        ld_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(CMD_PDOWN, pd_dat[i]);
            rd(OP_RD_CFG, v);
            check("report", v & 16'h0003, pd_rep[i]);
            check("float", flt, pd_rep[i][0]);
            check("pulldown", pdn, pd_rep[i][1]);
            check("amp", {amp, lad}, {2{pd_rep[i] == 2'h0}});
            wr({OP_WR_UPD, CHAN_ZERO}, pd_dat[i]);
            check("code", code, pd_dat[i]);
        end
        wr(CMD_BLOCK, 16'h0000);
        lvl = 1'b0;
        wait_n(4);
        clr_n = 1'b0;
        wait_n(10);
        check("code", code, CODE_ZERO);
        clr_n = 1'b1;
        rd(OP_RD_PRE, v);
        check("preload", v, CODE_ZERO);
        rd(OP_RD_CFG, v);
        check("report", v & 16'h0007, 16'h0004);
        lvl = 1'b1;
        wr({OP_WR_UPD, CHAN_ZERO}, 16'h1111);
        wr(CMD_CLEAR, 16'h0000);
        check("code", code, CODE_MID);
        rd(OP_RD_PRE, v);
        check("preload", v, CODE_MID);
        lvl = 1'b0;
        wait_n(4);
        nrst_i = 1'b0;
        wait_n(2);
        nrst_i = 1'b1;
        wait_n(8);
        check("code", code, CODE_ZERO);
        give_verdict();
    end
endmodule
